// ==== src/backlight_level_pkg.sv ====
// Constants shared by the backlight level current register bank.
package backlight_level_pkg;

  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_CONTROL    = 6'h01;
  localparam logic [5:0] IDX_STATUS     = 6'h02;
  localparam logic [5:0] IDX_OFFICE_MAX = 6'h0b;
  localparam logic [5:0] IDX_OFFICE_DIM = 6'h0c;
  localparam logic [5:0] IDX_DARK_MAX   = 6'h0d;
  localparam logic [5:0] IDX_DARK_DIM   = 6'h0e;

  // Field layout of the current code registers.
  localparam int CODE_W   = 7;
  localparam int CODE_MSB = 6;

  // Control register fields and value after reset.
  localparam int         CTRL_DIM_BIT = 0;
  localparam int         CTRL_LAW_BIT = 1;
  localparam logic [1:0] CTRL_RESET   = 2'h0;

  // Status register field positions.
  localparam int STAT_DIM_BIT   = 7;
  localparam int STAT_VALID_BIT = 8;

  // Value of every stored code after reset.
  localparam logic [6:0] CODE_RESET = 7'h00;

  // Ambient level encodings served by this bank.
  localparam logic [1:0] LEVEL_OFFICE = 2'h2;
  localparam logic [1:0] LEVEL_DARK   = 2'h3;

  // Full scale sink current in microamps and the code that reaches it.
  localparam int FULL_SCALE_UA = 30000;
  localparam int CODE_FULL     = 127;
  localparam int CODE_FULL_SQ  = CODE_FULL * CODE_FULL;
  localparam int UA_W          = 15;

  // Bus transfer states, one-hot.
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'h1,
    BUS_FETCH = 3'h2,
    BUS_ACK   = 3'h4
  } bus_state_e;

endpackage

// ==== src/level_code_mem.sv ====
// Four-entry storage for the level current codes with registered read ports.
`timescale 1ns/1ps
module level_code_mem
  import backlight_level_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              writeEn,
  input  wire logic [1:0]        writeSlot,
  input  wire logic [CODE_MSB:0] writeCode,
  input  wire logic [1:0]        busSlot,
  output logic      [CODE_MSB:0] busCode_q,
  input  wire logic [1:0]        driveSlot,
  output logic      [CODE_MSB:0] driveCode_q
);

  logic [CODE_MSB:0] mem_q [4];
  logic [CODE_MSB:0] mem_d [4];
  logic [CODE_MSB:0] busCode_d;
  logic [CODE_MSB:0] driveCode_d;

  // Next contents and read data; a read in the write cycle returns the old code.
  always_comb
  begin
    mem_d       = mem_q;
    busCode_d   = busCode_q;
    driveCode_d = driveCode_q;
    if (ce)
    begin
      if (writeEn)
      begin
        mem_d[writeSlot] = writeCode;
      end
      busCode_d   = mem_q[busSlot];
      driveCode_d = mem_q[driveSlot];
    end
  end

  // Storage registers.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_q       <= '{default: CODE_RESET};
      busCode_q   <= CODE_RESET;
      driveCode_q <= CODE_RESET;
    end
    else
    begin
      mem_q       <= mem_d;
      busCode_q   <= busCode_d;
      driveCode_q <= driveCode_d;
    end
  end

endmodule // level_code_mem

// ==== src/code_current_map.sv ====
// Converts a current code into a sink current in microamps under either law.
`timescale 1ns/1ps
module code_current_map
  import backlight_level_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              squareLaw,
  input  wire logic [CODE_MSB:0] code,
  output logic      [UA_W-1:0]   currentUa_q
);

  logic [31:0]     c;
  logic [31:0]     ua;
  logic [UA_W-1:0] currentUa_d;

  // Rounded linear or square scaling; both laws meet at the full scale code.
  always_comb
  begin
    c = {25'h0, code};
    if (squareLaw)
    begin
      ua = (c * c * FULL_SCALE_UA + CODE_FULL_SQ / 2) / CODE_FULL_SQ;
    end
    else
    begin
      ua = (c * FULL_SCALE_UA + CODE_FULL / 2) / CODE_FULL;
    end
    currentUa_d = ce ? ua[UA_W-1:0] : currentUa_q;
  end

  // Output register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      currentUa_q <= '0;
    end
    else
    begin
      currentUa_q <= currentUa_d;
    end
  end

  // Zero code gives no current and all ones give full scale.
  map_ends_a: assert property (@(posedge clk) disable iff (rst)
    ce && (code == 7'h00 || code == 7'h7f) |=> currentUa_q == (($past(code) == 7'h00) ? 15'h0 : 15'h7530))
    else $error("End codes do not map to zero and full scale.");

  // First code step is 0.236 mA linear and 0.002 mA square.
  map_step_a: assert property (@(posedge clk) disable iff (rst)
    ce && code == 7'h01 |=> currentUa_q == ($past(squareLaw) ? 15'h2 : 15'hec))
    else $error("First code step gives the wrong current.");

endmodule // code_current_map

// ==== src/backlight_level_current_regs.sv ====
// Office and dark backlight level current registers with an Avalon-MM slave.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps

// Summary of operation
// - Office level full current code lives in bits 6..0 and drives that level.
// - Office level dim code is stored separately in bits 6..0 of its own register.
// - Office level uses its dim code after dim timeout or while dim flag is set.
// - Dark level full current code lives in bits 6..0 and drives that level.
// - Dark level uses its dim code after dim timeout or while dim flag is set.
// - Codes map to current: zero 0 mA, linear 0.236 mA steps, all ones 30 mA.
module backlight_level_current_regs
  import backlight_level_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [7:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic [1:0]        ambientLevel,
  input  wire logic              dimTimeout,
  output logic      [CODE_MSB:0] activeCode,
  output logic      [UA_W-1:0]   sinkCurrentUa,
  output logic                   dimActive,
  output logic                   levelValid
);

  // True for the indexes of the four code registers.
  function automatic logic isCodeIdx(input logic [5:0] idx);
    return idx >= IDX_OFFICE_MAX && idx <= IDX_DARK_DIM;
  endfunction

  // Storage slot of a code register index.
  function automatic logic [1:0] slotOf(input logic [5:0] idx);
    logic [5:0] diff;
    diff = idx - IDX_OFFICE_MAX;
    return diff[1:0];
  endfunction

  bus_state_e        state_q;
  bus_state_e        state_d;
  logic [31:0]       readData_q;
  logic [31:0]       readData_d;
  logic [1:0]        ctrl_q;
  logic [1:0]        ctrl_d;
  logic [5:0]        idx;
  logic              memWe;
  logic [CODE_MSB:0] busCode;
  logic [CODE_MSB:0] driveCode;
  logic              dimReq;
  logic              levelOk;
  logic [1:0]        driveSlot;
  logic              valid1_q;
  logic              valid1_d;
  logic              dim1_q;
  logic              dim1_d;
  logic [CODE_MSB:0] activeCode_q;
  logic [CODE_MSB:0] activeCode_d;
  logic              dimActive_q;
  logic              dimActive_d;
  logic              levelValid_q;
  logic              levelValid_d;

  assign idx = address[7:2];

  // Transfer sequencer: request, fetch, then answer with waitrequest low.
  always_comb
  begin
    state_d = state_q;
    if (ce)
    begin
      case (state_q)
        BUS_IDLE:  state_d = (read || write) ? BUS_FETCH : BUS_IDLE;
        BUS_FETCH: state_d = BUS_ACK;
        BUS_ACK:   state_d = BUS_IDLE;
        default:   state_d = BUS_IDLE;
      endcase
    end
  end

  // A frozen answer cycle keeps waitrequest high, so the master never takes an answer that was not applied.
  assign waitrequest = !(ce && state_q == BUS_ACK);

  // Writes take effect only at the answering edge; bit 7 is dropped.
  assign memWe = ce && state_q == BUS_ACK && write && byteenable[0] && isCodeIdx(idx);

  // Control register: dim flag and law select.
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (ce && state_q == BUS_ACK && write && byteenable[0] && idx == IDX_CONTROL)
    begin
      ctrl_d = writedata[1:0];
    end
  end

  // Read data is captured in the fetch cycle from the addressed register.
  always_comb
  begin
    readData_d = readData_q;
    if (ce && state_q == BUS_FETCH)
    begin
      readData_d = '0;
      if (isCodeIdx(idx))
      begin
        readData_d = {25'h0, busCode};
      end
      else if (idx == IDX_CONTROL)
      begin
        readData_d = {30'h0, ctrl_q};
      end
      else if (idx == IDX_STATUS)
      begin
        readData_d = {23'h0, levelValid_q, dimActive_q, activeCode_q};
      end
    end
  end

  // Bus side registers.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q    <= BUS_IDLE;
      readData_q <= '0;
      ctrl_q     <= CTRL_RESET;
    end
    else
    begin
      state_q    <= state_d;
      readData_q <= readData_d;
      ctrl_q     <= ctrl_d;
    end
  end

  assign readdata = readData_q;

  // Dim request and code selection for the current ambient level.
  assign dimReq    = dimTimeout || ctrl_q[CTRL_DIM_BIT];
  assign levelOk   = ambientLevel == LEVEL_OFFICE || ambientLevel == LEVEL_DARK;
  assign driveSlot = {ambientLevel == LEVEL_DARK, dimReq};

  level_code_mem u_mem (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .writeEn     (memWe),
    .writeSlot   (slotOf(idx)),
    .writeCode   (writedata[CODE_MSB:0]),
    .busSlot     (slotOf(idx)),
    .busCode_q   (busCode),
    .driveSlot   (driveSlot),
    .driveCode_q (driveCode)
  );

  // Drive pipeline: selected code is forced to zero outside levels two and three.
  always_comb
  begin
    valid1_d     = valid1_q;
    dim1_d       = dim1_q;
    activeCode_d = activeCode_q;
    dimActive_d  = dimActive_q;
    levelValid_d = levelValid_q;
    if (ce)
    begin
      valid1_d     = levelOk;
      dim1_d       = dimReq;
      activeCode_d = valid1_q ? driveCode : CODE_RESET;
      dimActive_d  = valid1_q && dim1_q;
      levelValid_d = valid1_q;
    end
  end

  // Drive side registers.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      valid1_q     <= 1'b0;
      dim1_q       <= 1'b0;
      activeCode_q <= CODE_RESET;
      dimActive_q  <= 1'b0;
      levelValid_q <= 1'b0;
    end
    else
    begin
      valid1_q     <= valid1_d;
      dim1_q       <= dim1_d;
      activeCode_q <= activeCode_d;
      dimActive_q  <= dimActive_d;
      levelValid_q <= levelValid_d;
    end
  end

  assign activeCode = activeCode_q;
  assign dimActive  = dimActive_q;
  assign levelValid = levelValid_q;

  code_current_map u_map (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .squareLaw   (ctrl_q[CTRL_LAW_BIT]),
    .code        (activeCode_q),
    .currentUa_q (sinkCurrentUa)
  );

  // Shadow copies of the written codes, kept only for checking.
  logic [CODE_MSB:0] shadow_q [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_shadow
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          shadow_q[g] <= CODE_RESET;
        end
        else if (memWe && slotOf(idx) == 2'(g))
        begin
          shadow_q[g] <= writedata[CODE_MSB:0];
        end
      end
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // A steady level with no write in flight, sampled over two enabled cycles.
  sequence steadyLevel(logic [1:0] lvl, logic dim);
    (ce && ambientLevel == lvl && dimReq == dim && !memWe) ##1 (ce && !memWe);
  endsequence

  // A request taken by the idle sequencer in an enabled cycle.
  sequence busTaken;
    ce && state_q == BUS_IDLE && (read || write);
  endsequence

  // A level that this bank does not serve, followed by an enabled cycle.
  sequence unservedLevel;
    (ce && !levelOk) ##1 ce;
  endsequence

  office_full_a: assert property (steadyLevel(LEVEL_OFFICE, 1'b0) |=> activeCode_q == shadow_q[0])
    else $error("Office level does not drive its full code.");

  office_dim_a: assert property (steadyLevel(LEVEL_OFFICE, 1'b1) |=> activeCode_q == shadow_q[1])
    else $error("Office level does not drive its dim code.");

  dark_full_a: assert property (steadyLevel(LEVEL_DARK, 1'b0) |=> activeCode_q == shadow_q[2])
    else $error("Dark level does not drive its full code.");

  dark_dim_a: assert property (steadyLevel(LEVEL_DARK, 1'b1) |=> activeCode_q == shadow_q[3])
    else $error("Dark level does not drive its dim code.");

  dim_follow_a: assert property ((ce && levelOk) ##1 ce |=> dimActive_q == $past(dimReq, 2))
    else $error("Dim state does not follow timeout or dim flag.");

  rsvd_zero_a: assert property (!waitrequest && read && isCodeIdx(idx) |-> readdata[31:7] == 25'h0)
    else $error("Reserved bits of a code register read as nonzero.");

  bus_answer_a: assert property (busTaken ##1 ce ##1 ce |-> !waitrequest)
    else $error("Bus request not answered in the third cycle.");

  code_readback_a: assert property (!waitrequest && read && ce && idx == IDX_OFFICE_MAX && !$past(memWe, 1)
    |-> readdata[CODE_MSB:0] == shadow_q[0])
    else $error("Office full code does not read back.");

  // Levels other than office and dark drive no code and report nothing valid.
  level_off_a: assert property (unservedLevel |=> activeCode_q == CODE_RESET
    && !levelValid_q && !dimActive_q)
    else $error("An unserved level still drives a code.");

  // A low clock enable freezes the sequencer, the control bits and the drive outputs.
  freeze_hold_a: assert property (!ce |=> $stable(state_q) && $stable(ctrl_q) && $stable(readData_q)
    && $stable(activeCode_q) && $stable(dimActive_q))
    else $error("State moved while the clock enable was low.");

  // A frozen answer cycle must not look like an answer to the master.
  frozen_wait_a: assert property (!ce |-> waitrequest)
    else $error("A frozen sequencer answered the bus.");

  // A control write lands at the answering edge and sets the dim flag and law.
  ctrl_write_a: assert property (ce && !waitrequest && write && byteenable[0] && idx == IDX_CONTROL
    |=> ctrl_q == $past(writedata[1:0]))
    else $error("Control write did not land.");

  // Reads of unmapped indexes return an all-zero word.
  unmapped_zero_a: assert property (!waitrequest && read && !isCodeIdx(idx) && idx != IDX_CONTROL
    && idx != IDX_STATUS |-> readdata == 32'h0)
    else $error("Unmapped read returned nonzero data.");

  // Control reads show only the two control bits.
  ctrl_upper_a: assert property (!waitrequest && read && idx == IDX_CONTROL |-> readdata[31:2] == 30'h0)
    else $error("Unused control bits read as nonzero.");

  // Status reads show nothing above the valid bit.
  status_upper_a: assert property (!waitrequest && read && idx == IDX_STATUS |-> readdata[31:9] == 23'h0)
    else $error("Unused status bits read as nonzero.");

endmodule // backlight_level_current_regs

// ==== testbench/backlight_level_current_regs_tb.sv ====
// Self-checking testbench for the backlight level current register bank.
`timescale 1ns/1ps
module backlight_level_current_regs_tb
  import backlight_level_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              ce = 1'b1;
  logic [7:0]        address = 8'h00;
  logic              read = 1'b0;
  logic              write = 1'b0;
  logic [31:0]       writedata = 32'h0;
  logic [3:0]        byteenable = 4'hf;
  logic [31:0]       readdata;
  logic              waitrequest;
  logic [1:0]        ambientLevel = 2'h0;
  logic              dimTimeout = 1'b0;
  logic [CODE_MSB:0] activeCode;
  logic [UA_W-1:0]   sinkCurrentUa;
  logic              dimActive;
  logic              levelValid;
  int                err_total = 0;
  int                check_count = 0;
  logic [31:0]       rdata;
  logic [7:0]        codeAddr [4] = '{8'h2c, 8'h30, 8'h34, 8'h38};
  logic [31:0]       codeData [4] = '{32'h000000a5, 32'hffffff5a, 32'h80000013, 32'h0000ff6c};
  logic [6:0]        lawCode [8] = '{7'h00, 7'h01, 7'h40, 7'h7f, 7'h00, 7'h01, 7'h03, 7'h7f};
  logic [31:0]       lawUa [8] = '{32'd0, 32'd236, 32'd15118, 32'd30000, 32'd0, 32'd2, 32'd17, 32'd30000};

  backlight_level_current_regs u_backlight_level_current_regs (
    .clk           (clk),
    .rst           (rst),
    .ce            (ce),
    .address       (address),
    .read          (read),
    .write         (write),
    .writedata     (writedata),
    .byteenable    (byteenable),
    .readdata      (readdata),
    .waitrequest   (waitrequest),
    .ambientLevel  (ambientLevel),
    .dimTimeout    (dimTimeout),
    .activeCode    (activeCode),
    .sinkCurrentUa (sinkCurrentUa),
    .dimActive     (dimActive),
    .levelValid    (levelValid)
  );

  // Free-running 20 MHz clock.
  always #25 clk = ~clk;

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("Checks made: %0d, mismatches: %0d.", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Compares one seen value against its expected value.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon transfer held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 200);
    if (n >= 200)
      err_total++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Register write helper.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Register read helper that checks the word returned.
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(name, q, exp);
  endtask

  // Sets the drive inputs, lets the pipeline settle and checks the drive outputs.
  task automatic drv(input logic [1:0] lvl, input logic tmo, input logic [6:0] code, input logic dim,
                     input logic valid);
    @(posedge clk);
    ambientLevel <= lvl;
    dimTimeout <= tmo;
    repeat (5) @(posedge clk);
    check("activeCode", {25'h0, activeCode}, {25'h0, code});
    check("dimActive", {31'h0, dimActive}, {31'h0, dim});
    check("levelValid", {31'h0, levelValid}, {31'h0, valid});
  endtask

  // Stops a hung run.
  initial
  begin
    repeat (6000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  // Main test sequence.
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      rd("code after reset", codeAddr[i], 32'h0);
    for (int i = 0; i < 4; i++)
      wr(codeAddr[i], codeData[i]);
    for (int i = 0; i < 4; i++)
      rd("code readback", codeAddr[i], codeData[i] & 32'h7f);
    byteenable <= 4'he;
    wr(8'h2c, 32'h11);
    byteenable <= 4'hf;
    rd("masked write", 8'h2c, 32'h25);
    wr(8'h3c, 32'h7f);
    rd("unmapped", 8'h3c, 32'h0);
    wr(8'h04, 32'h0);
    drv(2'h2, 1'b0, 7'h25, 1'b0, 1'b1);
    drv(2'h2, 1'b1, 7'h5a, 1'b1, 1'b1);
    drv(2'h2, 1'b0, 7'h25, 1'b0, 1'b1);
    wr(8'h04, 32'h1);
    rd("control", 8'h04, 32'h1);
    drv(2'h2, 1'b0, 7'h5a, 1'b1, 1'b1);
    drv(2'h3, 1'b0, 7'h6c, 1'b1, 1'b1);
    rd("status", 8'h08, 32'h1ec);
    wr(8'h04, 32'h0);
    drv(2'h3, 1'b0, 7'h13, 1'b0, 1'b1);
    drv(2'h3, 1'b1, 7'h6c, 1'b1, 1'b1);
    drv(2'h1, 1'b0, 7'h00, 1'b0, 1'b0);
    drv(2'h2, 1'b0, 7'h25, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h2c, {25'h0, lawCode[i]});
      wr(8'h04, (i < 4) ? 32'h0 : 32'h2);
      repeat (6) @(posedge clk);
      check("sinkCurrentUa", {17'h0, sinkCurrentUa}, lawUa[i]);
    end
    // Clock enable dropped for three cycles while the write sits in its answer cycle.
    fork
      wr(8'h30, 32'h41);
      begin
        repeat (3) @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    rd("frozen write", 8'h30, 32'h41);
    end_of_test();
  end
endmodule // backlight_level_current_regs_tb
